// ---- tp_consts.vh ----
// constants for the test point strap and debug port
`ifndef TP_CONSTS_VH
`define TP_CONSTS_VH

// port geometry
`define TP_PIN_W       8
`define TP_SEL_W       3
`define TP_ACC_W       24
`define TP_ACC_ONE     64'd16777216

// strap selections
`define TP_SEL_QUIET   3'h0
`define TP_SEL_CLKDBG  3'h2
`define TP_SEL_RST     3'h0

// fixed levels in clock debug selection: pins 3, 5 and 6 high, pin 4 low
`define TP_LVL_CLKDBG  8'h68
`define TP_PIN_F60     0
`define TP_PIN_F30     1
`define TP_PIN_FVAR    2
`define TP_PIN_F7P5    7

// rates in hertz
`define TP_CLK_HZ      64'd125000000
`define TP_F60_HZ      64'd60000000
`define TP_F30_HZ      64'd30000000
`define TP_F7P5_HZ     64'd7500000
`define TP_FVMIN_HZ    64'd700000
`define TP_FVMAX_HZ    64'd22500000
`define TP_FVDEF_HZ    64'd10000000

`endif

// ---- tp_nco.v ----
// phase accumulator clock generator for one debug clock output
`timescale 1ns/10ps
module tp_nco (
	// clock and reset
	input  wire        clock,
	input  wire        srst,
	// control
	input  wire        enable,
	input  wire [23:0] step,
	// output
	output reg         clkOut
);

	reg [23:0] phase;

	// the top phase bit is the clock; with a non-dividing rate the edges
	// jitter by one core period, which is fine for a lab probe
	always @(posedge clock) begin
		if (srst || !enable) begin
			phase  <= 24'h000000;
			clkOut <= 1'b0;
		end else begin
			phase  <= phase + step;
			clkOut <= phase[23];
		end
	end

endmodule

// ---- tp_strap_port.v ----
// test point port: strap capture at reset release, then debug outputs
// How it works
// - pins stay undriven while system reset held
// - pins become outputs after reset release, clock debug selection only
// - capture straps at release, hold until reset
// - pad pull-down makes open straps read zero
// - all-zero selection keeps every pin high impedance
// - sample straps only on reset rising edge
// - later strap changes ignored until next reset
// - clock debug: 60 MHz pin0, 30 MHz pin1
// - pin2 variable clock, pin7 7.5 MHz, fixed levels
// - software may change selection only after reset release
// - reset rising edge also starts initialisation
`timescale 1ns/10ps
`include "tp_consts.vh"
module tp_strap_port (
	// clock and chip logic reset
	input  wire        clock,
	input  wire        srst,
	// reset pin from the board, asynchronous
	input  wire        systemReset_n,
	// debug probe pins, split into input, output and enable
	input  wire [7:0]  debugProbePinsIn,
	output reg  [7:0]  debugProbePinsOut,
	output reg  [7:0]  debugProbePinsOe_n,
	// software selection
	input  wire        selWrite,
	input  wire [2:0]  selData,
	// software variable clock step
	input  wire        rateWrite,
	input  wire [23:0] rateData,
	// status
	output reg  [2:0]  strapSelectBits,
	output reg  [2:0]  activeSelect,
	output reg  [23:0] activeRate,
	output reg         portActive,
	output reg         initStart
);

	////////////////////////////////////////////////////////////////////////
	// rate constants

	localparam [63:0] STEP60_W   = (`TP_F60_HZ * `TP_ACC_ONE) / `TP_CLK_HZ;
	localparam [63:0] STEP30_W   = (`TP_F30_HZ * `TP_ACC_ONE) / `TP_CLK_HZ;
	localparam [63:0] STEP7P5_W  = (`TP_F7P5_HZ * `TP_ACC_ONE) / `TP_CLK_HZ;
	// lower bound rounds up, upper bound rounds down, so the clamp never
	// leaves the allowed band
	localparam [63:0] STEPVMIN_W =
		(`TP_FVMIN_HZ * `TP_ACC_ONE + `TP_CLK_HZ - 64'd1) / `TP_CLK_HZ;
	localparam [63:0] STEPVMAX_W = (`TP_FVMAX_HZ * `TP_ACC_ONE) / `TP_CLK_HZ;
	localparam [63:0] STEPVDEF_W = (`TP_FVDEF_HZ * `TP_ACC_ONE) / `TP_CLK_HZ;

	localparam [23:0] STEP60   = STEP60_W[23:0];
	localparam [23:0] STEP30   = STEP30_W[23:0];
	localparam [23:0] STEP7P5  = STEP7P5_W[23:0];
	localparam [23:0] STEPVMIN = STEPVMIN_W[23:0];
	localparam [23:0] STEPVMAX = STEPVMAX_W[23:0];
	localparam [23:0] STEPVDEF = STEPVDEF_W[23:0];

	// port states, one-hot
	localparam [1:0] ST_STRAP = 2'h1;
	localparam [1:0] ST_RUN   = 2'h2;

	////////////////////////////////////////////////////////////////////////
	// decode helpers

	function isClockDebug;
		input [2:0] sel;
		begin
			isClockDebug = (sel == `TP_SEL_CLKDBG);
		end
	endfunction

	function [23:0] clampRate;
		input [23:0] req;
		begin
			if (req < STEPVMIN)
				clampRate = STEPVMIN;
			else if (req > STEPVMAX)
				clampRate = STEPVMAX;
			else
				clampRate = req;
		end
	endfunction

	function [23:0] ncoStep;
		input [1:0]  idx;
		input [23:0] varStep;
		begin
			case (idx)
				2'h0:    ncoStep = STEP60;
				2'h1:    ncoStep = STEP30;
				2'h2:    ncoStep = varStep;
				default: ncoStep = STEP7P5;
			endcase
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers

	reg       resetMeta;
	reg       resetSync;
	reg       resetSyncPrev;
	reg [7:0] pinsMeta;
	reg [7:0] pinsSync;

	// the reset pin and the straps come from the board, so both pass two
	// flops; the straps keep the same latency as the reset so the capture
	// sees the levels that stood at the release
	always @(posedge clock) begin
		if (srst) begin
			resetMeta     <= 1'b0;
			resetSync     <= 1'b0;
			resetSyncPrev <= 1'b0;
			pinsMeta      <= 8'h00;
			pinsSync      <= 8'h00;
		end else begin
			resetMeta     <= systemReset_n;
			resetSync     <= resetMeta;
			resetSyncPrev <= resetSync;
			pinsMeta      <= debugProbePinsIn;
			pinsSync      <= pinsMeta;
		end
	end

	// only a low-to-high step of the synchronised reset counts
	wire releaseEdge = resetSync && !resetSyncPrev;

	////////////////////////////////////////////////////////////////////////
	// strap capture and selection

	reg [1:0]  state;
	reg [1:0]  next_state;
	reg [2:0]  swSelect;
	reg [23:0] varStep;

	always @* begin
		next_state = state;
		case (state)
			ST_STRAP: begin
				if (releaseEdge)
					next_state = ST_RUN;
			end
			ST_RUN: begin
				if (!resetSync)
					next_state = ST_STRAP;
			end
			default: begin
				next_state = ST_STRAP;
			end
		endcase
	end

	always @(posedge clock) begin
		if (srst) begin
			state           <= ST_STRAP;
			strapSelectBits <= `TP_SEL_RST;
			swSelect        <= `TP_SEL_RST;
			varStep         <= STEPVDEF;
			initStart       <= 1'b0;
		end else begin
			state     <= next_state;
			initStart <= (state == ST_STRAP) && releaseEdge;
			if ((state == ST_STRAP) && releaseEdge) begin
				// open straps read zero through the pad pull-down
				strapSelectBits <= pinsSync[2:0];
				swSelect        <= pinsSync[2:0];
			end else if ((state == ST_RUN) && selWrite) begin
				// writes while reset holds are dropped; the strap owns
				// the selection until release
				swSelect <= selData;
			end
			// strap levels seen in run state are never looked at again
			if ((state == ST_RUN) && rateWrite)
				varStep <= clampRate(rateData);
		end
	end

	wire running = (state == ST_RUN);
	wire clkDbg  = running && isClockDebug(swSelect);

	////////////////////////////////////////////////////////////////////////
	// debug clock generators

	wire [3:0] ncoClk;

	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : genNco
			localparam integer IDXI = g;
			localparam [1:0]   IDX  = IDXI[1:0];
			tp_nco uNco (
				.clock  (clock),
				.srst   (srst),
				.enable (clkDbg),
				.step   (ncoStep(IDX, varStep)),
				.clkOut (ncoClk[g])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// pin drivers

	reg [7:0] next_pinsOut;
	reg [7:0] next_pinsOe_n;

	always @* begin
		next_pinsOut  = 8'h00;
		next_pinsOe_n = 8'hff;
		if (clkDbg) begin
			next_pinsOe_n              = 8'h00;
			next_pinsOut               = `TP_LVL_CLKDBG;
			next_pinsOut[`TP_PIN_F60]  = ncoClk[0];
			next_pinsOut[`TP_PIN_F30]  = ncoClk[1];
			next_pinsOut[`TP_PIN_FVAR] = ncoClk[2];
			next_pinsOut[`TP_PIN_F7P5] = ncoClk[3];
		end
	end

	// the pin drivers and status sit behind one more flop so every output
	// is a register; release from driving therefore lags the reset pin by
	// four core cycles
	always @(posedge clock) begin
		if (srst) begin
			debugProbePinsOut  <= 8'h00;
			debugProbePinsOe_n <= 8'hff;
			activeSelect       <= `TP_SEL_RST;
			activeRate         <= STEPVDEF;
			portActive         <= 1'b0;
		end else begin
			debugProbePinsOut  <= next_pinsOut;
			debugProbePinsOe_n <= next_pinsOe_n;
			activeSelect       <= swSelect;
			activeRate         <= varStep;
			portActive         <= running;
		end
	end

endmodule

// ---- tp_board_model.sv ----
// board side of the test point pins: optional pull-up straps over pad pull-downs
`timescale 1ns/10ps
module tp_board_model (
	// straps, a one is a fitted pull-up
	input  logic [7:0] pullUp,
	// pad side of the device
	input  logic [7:0] pinsOut,
	input  logic [7:0] pinsOe_n,
	output logic [7:0] pinsIn
);
	// an open pin settles low through its pull-down
	always_comb
		for (int i = 0; i < 8; i++)
			pinsIn[i] = pinsOe_n[i] ? pullUp[i] : pinsOut[i];
endmodule

// ---- tp_strap_port_chk.sv ----
// assertions on the ports of the test point strap port
`timescale 1ns/10ps
module tp_strap_port_chk (
	input wire       clock,
	input wire       srst,
	input wire       systemReset_n,
	input wire [7:0] debugProbePinsIn,
	input wire [7:0] debugProbePinsOut,
	input wire [7:0] debugProbePinsOe_n,
	input wire       selWrite,
	input wire [2:0] selData,
	input wire [2:0] strapSelectBits,
	input wire [2:0] activeSelect,
	input wire       portActive,
	input wire       initStart
);
	default clocking @(posedge clock); endclocking
	default disable iff (srst);
	a_pins_undriven: assert property (!systemReset_n [*5] |-> debugProbePinsOe_n == 8'hff)
		else $error("pins driven in reset");
	a_init_pulse: assert property ($rose(systemReset_n) |-> ##3 initStart ##1 !initStart)
		else $error("init pulse wrong");
	a_strap_capture: assert property ($rose(systemReset_n) |-> ##3
		strapSelectBits == $past(debugProbePinsIn[2:0], 3)) else $error("strap not captured");
	// a mid-run srst clears the straps, so skip the edge just after it
	a_strap_hold: assert property (!initStart && !$past(srst) |-> $stable(strapSelectBits))
		else $error("strap changed");
	// the selection status is one flop behind the capture pulse
	a_select_loaded: assert property (initStart |=> activeSelect == strapSelectBits)
		else $error("selection not loaded");
	// enables and selection status leave the same flop stage together
	a_quiet_select: assert property (activeSelect != 3'h2 |-> debugProbePinsOe_n == 8'hff)
		else $error("pins driven when quiet");
	a_clock_levels: assert property (activeSelect == 3'h2 && $past(activeSelect) == 3'h2 && portActive
		&& $past(portActive) |-> debugProbePinsOe_n == 8'h00 && debugProbePinsOut[6:3] == 4'hd)
		else $error("debug levels wrong");
	// the reset pin three samples back decides whether the port still runs at the take
	a_sel_write: assert property (portActive && !initStart && selWrite && $past(systemReset_n, 3)
		|-> ##2 activeSelect == $past(selData, 2))
		else $error("write lost");
endmodule
bind tp_strap_port tp_strap_port_chk i_chk (.clock, .srst, .systemReset_n, .debugProbePinsIn, .debugProbePinsOut,
	.debugProbePinsOe_n, .selWrite, .selData, .strapSelectBits, .activeSelect, .portActive, .initStart);

// ---- tb_tp_strap_port.sv ----
// self-checking bench for the test point strap port
`timescale 1ns/10ps
module tb_tp_strap_port;
	logic        clock = 0;
	logic        srst = 1;
	logic        systemReset_n = 0;
	logic        selWrite = 0;
	logic        rateWrite = 0;
	logic [2:0]  selData = 0;
	logic [23:0] rateData = 0;
	logic [7:0]  pullUp = 0;
	logic [7:0]  pinsIn, pinsOut, pinsOe_n, s;
	logic [3:0]  p;
	logic [2:0]  strapBits, actSel;
	logic [23:0] actRate, d;
	logic        portActive, initStart;
	logic [2:0]  expQ[$];
	logic [31:0] rnd = 32'h4d7b;
	int          miscompares = 0;
	int          compares = 0;
	int          cycles = 0;
	int          n[4];

	tp_strap_port i_dut (.clock, .srst, .systemReset_n, .debugProbePinsIn(pinsIn), .debugProbePinsOut(pinsOut),
		.debugProbePinsOe_n(pinsOe_n), .selWrite, .selData, .rateWrite, .rateData,
		.strapSelectBits(strapBits), .activeSelect(actSel), .activeRate(actRate), .portActive, .initStart);
	tp_board_model i_board (.pullUp, .pinsOut, .pinsOe_n, .pinsIn);

	initial forever #4 clock = ~clock;
	////////////////////////////////////////
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		return x ^ (x << 5);
	endfunction
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// pin reset pulse long enough for the synchroniser, new strap set while held
	task automatic boot(input logic [7:0] v);
		systemReset_n = 0;
		repeat (5) @(negedge clock);
		check(pinsOe_n, 8'hff);
		check(portActive, 0);
		pullUp = v;
		repeat (2) @(negedge clock);
		systemReset_n = 1;
		expQ.push_back(v[2:0]);
		repeat (8) @(negedge clock);
	endtask
	// on a capture pulse the captured strap bits are matched against the queued straps
	always @(posedge clock) begin
		cycles++;
		if (cycles == 2000) begin
			miscompares++;
			end_of_test();
		end
		if (initStart === 1'b1)
			check(strapBits, expQ.pop_front());
	end
	////////////////////////////////////////
	initial begin
		repeat (20) @(negedge clock);
		srst = 0;
		for (int t = 0; t < 10; t++) begin
			rnd = xs(rnd);
			s = (t < 2) ? 8'(t * 2) : rnd[7:0];
			boot(s);
			pullUp = ~s;
			repeat (4) @(negedge clock);
			check(strapBits, s[2:0]);
			check(actSel, s[2:0]);
			check(pinsOe_n, (s[2:0] == 3'h2) ? 8'h00 : 8'hff);
			check(portActive, 1);
		end
		$display("strap tests done");
		for (int v = 0; v < 8; v++) begin
			selWrite = 1;
			selData = 3'(v);
			@(negedge clock);
			selWrite = 0;
			repeat (3) @(negedge clock);
			check(pinsOe_n, (v == 2) ? 8'h00 : 8'hff);
			if (v == 2) begin
				check(pinsOut[6:3], 4'hd);
				n = '{0, 0, 0, 0};
				repeat (200) begin
					p = {pinsOut[7], pinsOut[2:0]};
					@(negedge clock);
					p = ~p & {pinsOut[7], pinsOut[2:0]};
					foreach (n[i]) n[i] += p[i];
				end
				check(n[0] inside {[95:97]}, 1);
				check(n[1] inside {[47:49]}, 1);
				check(n[2] inside {[15:17]}, 1);
				check(n[3] inside {[11:13]}, 1);
			end
		end
		$display("selection tests done");
		for (int t = 0; t < 8; t++) begin
			rnd = xs(rnd);
			d = (t == 0) ? 24'h0 : (t == 1) ? 24'hffffff : {2'h0, rnd[21:0]};
			rateWrite = 1;
			rateData = d;
			@(negedge clock);
			rateWrite = 0;
			repeat (2) @(negedge clock);
			check(actRate, (d < 24'h016f01) ? 24'h016f01 : (d > 24'h2e147a) ? 24'h2e147a : d);
		end
		$display("rate tests done");
		check(expQ.size(), 0);
		end_of_test();
	end
endmodule
